// *** cwd_addr_step.sv ***
// Access address from the inclusive last address and the items left
`timescale 1ns/100ps
`include "cwd_defines.svh"
module cwd_addr_step (
   input  wire logic [31:0] lastAddr,
   input  wire logic [1:0]  stepCode,
   input  wire logic [9:0]  itemsLeft,
   output logic      [31:0] accAddr
);
   logic [31:0] backOff;

   always_comb begin
      backOff = {22'h0, itemsLeft} << stepCode;
      if (stepCode == `CWD_STEP_NONE) begin
         accAddr = lastAddr;
      end else begin
         accAddr = lastAddr - backOff;
      end
   end
endmodule : cwd_addr_step

// *** cwd_channel_ctl.sv ***
// Channel control word decode and item mover
// Behaviour
// - Destination step from bits 31:30, 3 fixed
// - Fixed destination stays at last address
// - Destination item width from bits 29:28
// - Source step from bits 27:26, 3 fixed
// - Fixed source stays at last address
// - Source item width from bits 25:24
// - Re-arbitrate after two-power-of-code transfers
// - Codes 0-9 up to 512, above 1024
// - Last addresses are inclusive final addresses
// - Count field is items minus one
`timescale 1ns/100ps
`include "cwd_defines.svh"
module cwd_channel_ctl (
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic [7:0]  regAddr,
   input  wire logic [31:0] regWdata,
   input  wire logic        regWrStb,
   input  wire logic        regRdStb,
   output logic      [31:0] regRdata,
   output logic             memReq,
   output logic             memWe,
   output logic      [31:0] memAddr,
   output logic      [1:0]  memSize,
   output logic      [31:0] memWdata,
   input  wire logic        memAck,
   input  wire logic [31:0] memRdata,
   output logic             rearbReq,
   input  wire logic        arbGrant
);
   cwd_pkg::cwd_state_t state_ff;
   cwd_pkg::cwd_state_t nxt_state;
   logic [31:0] srcEnd_ff;
   logic [31:0] nxt_srcEnd;
   logic [31:0] dstEnd_ff;
   logic [31:0] nxt_dstEnd;
   logic [31:0] ctl_ff;
   logic [31:0] nxt_ctl;
   logic [9:0]  burstCnt_ff;
   logic [9:0]  nxt_burstCnt;
   logic [31:0] data_ff;
   logic [31:0] nxt_data;
   logic        cfgErr_ff;
   logic        nxt_cfgErr;
   logic [31:0] rdData_ff;
   logic [31:0] nxt_rdData;

   logic [1:0]  dstStep;
   logic [1:0]  dstWidth;
   logic [1:0]  srcStep;
   logic [1:0]  srcWidth;
   logic [3:0]  arbCode;
   logic [9:0]  itemsLeft;
   logic [10:0] burstLen;
   logic        lastInBurst;
   logic        ctlWr;
   logic        startOk;
   logic [31:0] srcAddr;
   logic [31:0] dstAddr;
   logic [31:0] statusWord;
   logic [31:0] sideAddr [2];

   assign dstStep   = ctl_ff[`CWD_DST_STEP_HI:`CWD_DST_STEP_LO];
   assign dstWidth  = ctl_ff[`CWD_DST_SIZE_HI:`CWD_DST_SIZE_LO];
   assign srcStep   = ctl_ff[`CWD_SRC_STEP_HI:`CWD_SRC_STEP_LO];
   assign srcWidth  = ctl_ff[`CWD_SRC_SIZE_HI:`CWD_SRC_SIZE_LO];
   assign arbCode   = ctl_ff[`CWD_ARB_HI:`CWD_ARB_LO];
   assign itemsLeft = ctl_ff[`CWD_CNT_HI:`CWD_CNT_LO];

   // Burst length, capped at the largest possible transfer
   always_comb begin
      if (arbCode >= `CWD_ARB_CAP_CODE) begin
         burstLen = 11'h1 << `CWD_ARB_CAP_SHIFT;
      end else begin
         burstLen = 11'h1 << arbCode;
      end
   end

   assign lastInBurst = ({1'b0, burstCnt_ff} == (burstLen - 11'h1));

   genvar side;
   generate
      for (side = 0; side < 2; side++) begin : g_addr
         cwd_addr_step u_step (
            .lastAddr  ((side == 0) ? srcEnd_ff : dstEnd_ff),
            .stepCode  ((side == 0) ? srcStep : dstStep),
            .itemsLeft (itemsLeft),
            .accAddr   (sideAddr[side])
         );
      end
   endgenerate

   assign srcAddr = sideAddr[0];
   assign dstAddr = sideAddr[1];

   // Bus side of the mover
   assign memReq   = (state_ff == cwd_pkg::RD) || (state_ff == cwd_pkg::WR);
   assign memWe    = (state_ff == cwd_pkg::WR);
   assign memAddr  = memWe ? dstAddr : srcAddr;
   assign memSize  = memWe ? dstWidth : srcWidth;
   assign memWdata = data_ff;
   assign rearbReq = (state_ff == cwd_pkg::ARB);

   assign ctlWr   = regWrStb && (regAddr == `CWD_OFF_CTL);
   assign startOk = (regWdata[`CWD_MODE_HI:`CWD_MODE_LO] != `CWD_MODE_STOP)
                 && (regWdata[`CWD_DST_SIZE_HI:`CWD_DST_SIZE_LO]
                     != `CWD_SIZE_RSVD)
                 && (regWdata[`CWD_SRC_SIZE_HI:`CWD_SRC_SIZE_LO]
                     != `CWD_SIZE_RSVD);

   // Channel structure and mover state
   always_comb begin
      nxt_state    = state_ff;
      nxt_srcEnd   = srcEnd_ff;
      nxt_dstEnd   = dstEnd_ff;
      nxt_ctl      = ctl_ff;
      nxt_burstCnt = burstCnt_ff;
      nxt_data     = data_ff;
      nxt_cfgErr   = cfgErr_ff;
      unique case (state_ff)
         cwd_pkg::IDLE: begin
            if (regWrStb && (regAddr == `CWD_OFF_SRC_END)) begin
               nxt_srcEnd = regWdata;
            end
            if (regWrStb && (regAddr == `CWD_OFF_DST_END)) begin
               nxt_dstEnd = regWdata;
            end
            if (ctlWr) begin
               nxt_ctl      = regWdata;
               nxt_burstCnt = 10'h0;
               nxt_cfgErr   = (regWdata[`CWD_MODE_HI:`CWD_MODE_LO]
                               != `CWD_MODE_STOP) && !startOk;
               if (startOk) begin
                  nxt_state = cwd_pkg::RD;
               end
            end
         end
         cwd_pkg::RD: begin
            if (memAck) begin
               nxt_data  = memRdata;
               nxt_state = cwd_pkg::WR;
            end
         end
         cwd_pkg::WR: begin
            if (memAck) begin
               if (itemsLeft == 10'h0) begin
                  nxt_ctl[`CWD_MODE_HI:`CWD_MODE_LO] = `CWD_MODE_STOP;
                  nxt_state = cwd_pkg::IDLE;
               end else begin
                  nxt_ctl[`CWD_CNT_HI:`CWD_CNT_LO] = itemsLeft - 10'h1;
                  if (lastInBurst) begin
                     nxt_burstCnt = 10'h0;
                     nxt_state    = cwd_pkg::ARB;
                  end else begin
                     nxt_burstCnt = burstCnt_ff + 10'h1;
                     nxt_state    = cwd_pkg::RD;
                  end
               end
            end
         end
         cwd_pkg::ARB: begin
            if (arbGrant) begin
               nxt_state = cwd_pkg::RD;
            end
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_ff    <= cwd_pkg::IDLE;
         srcEnd_ff   <= 32'h0;
         dstEnd_ff   <= 32'h0;
         ctl_ff      <= 32'h0;
         burstCnt_ff <= 10'h0;
         data_ff     <= 32'h0;
         cfgErr_ff   <= 1'b0;
      end else begin
         state_ff    <= nxt_state;
         srcEnd_ff   <= nxt_srcEnd;
         dstEnd_ff   <= nxt_dstEnd;
         ctl_ff      <= nxt_ctl;
         burstCnt_ff <= nxt_burstCnt;
         data_ff     <= nxt_data;
         cfgErr_ff   <= nxt_cfgErr;
      end
   end

   // Register read port, data one cycle after the strobe
   always_comb begin
      statusWord = 32'h0;
      statusWord[`CWD_ST_BUSY]    = (state_ff != cwd_pkg::IDLE);
      statusWord[`CWD_ST_ARBWAIT] = (state_ff == cwd_pkg::ARB);
      statusWord[`CWD_ST_CFGERR]  = cfgErr_ff;
      statusWord[`CWD_CNT_HI:`CWD_CNT_LO] = itemsLeft;
      nxt_rdData = 32'h0;
      if (regRdStb) begin
         unique case (regAddr)
            `CWD_OFF_SRC_END: nxt_rdData = srcEnd_ff;
            `CWD_OFF_DST_END: nxt_rdData = dstEnd_ff;
            `CWD_OFF_CTL:     nxt_rdData = ctl_ff;
            `CWD_OFF_STATUS:  nxt_rdData = statusWord;
            default:          nxt_rdData = 32'h0;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rdData_ff <= 32'h0;
      end else begin
         rdData_ff <= nxt_rdData;
      end
   end

   assign regRdata = rdData_ff;

   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   property p_dst_fixed;
      memWe && (dstStep == `CWD_STEP_NONE) |-> memAddr == dstEnd_ff;
   endproperty
   a_dst_fixed: assert property (p_dst_fixed)
      else $error("fixed destination moved");

   property p_src_fixed;
      (state_ff == cwd_pkg::RD) && (srcStep == `CWD_STEP_NONE)
         |-> memAddr == srcEnd_ff;
   endproperty
   a_src_fixed: assert property (p_src_fixed)
      else $error("fixed source moved");

   property p_dst_step;
      memWe && (dstStep != `CWD_STEP_NONE) |->
         memAddr == dstEnd_ff - ({22'h0, itemsLeft} << dstStep);
   endproperty
   a_dst_step: assert property (p_dst_step)
      else $error("destination address step wrong");

   property p_src_step;
      (state_ff == cwd_pkg::RD) && (srcStep != `CWD_STEP_NONE) |->
         memAddr == srcEnd_ff - ({22'h0, itemsLeft} << srcStep);
   endproperty
   a_src_step: assert property (p_src_step)
      else $error("source address step wrong");

   property p_sizes;
      memWe |-> memSize == ctl_ff[`CWD_DST_SIZE_HI:`CWD_DST_SIZE_LO];
   endproperty
   a_sizes: assert property (p_sizes)
      else $error("item width does not follow the field");

   property p_rd_size;
      (state_ff == cwd_pkg::RD) |-> memSize == srcWidth && !memWe;
   endproperty
   a_rd_size: assert property (p_rd_size)
      else $error("read width not the source width");

   property p_arb_entry;
      $rose(state_ff == cwd_pkg::ARB) |->
         {1'b0, $past(burstCnt_ff)} == $past(burstLen) - 11'h1;
   endproperty
   a_arb_entry: assert property (p_arb_entry)
      else $error("re-arbitration at wrong transfer count");

   property p_arb_hold;
      rearbReq && !arbGrant |=> rearbReq;
   endproperty
   a_arb_hold: assert property (p_arb_hold)
      else $error("re-arbitration request dropped before grant");

   property p_arb_cap;
      (arbCode >= `CWD_ARB_CAP_CODE) |-> state_ff != cwd_pkg::ARB;
   endproperty
   a_arb_cap: assert property (p_arb_cap)
      else $error("capped burst re-arbitrated");

   property p_last_item;
      memWe && (itemsLeft == 10'h0) |-> memAddr == dstEnd_ff;
   endproperty
   a_last_item: assert property (p_last_item)
      else $error("last item not at last address");

   property p_done;
      memWe && memAck && (itemsLeft == 10'h0) |=>
         (state_ff == cwd_pkg::IDLE)
         && (ctl_ff[`CWD_MODE_HI:`CWD_MODE_LO] == `CWD_MODE_STOP);
   endproperty
   a_done: assert property (p_done)
      else $error("final item did not stop the channel");

   property p_count;
      memWe && memAck && (itemsLeft != 10'h0) |=>
         (itemsLeft == $past(itemsLeft) - 10'h1) && !memWe;
   endproperty
   a_count: assert property (p_count)
      else $error("remaining count not decremented");

   c_done:  cover property (memWe && memAck && (itemsLeft == 10'h0));
   c_arb:   cover property (rearbReq ##1 arbGrant);
   c_fixed: cover property (memWe && (dstStep == `CWD_STEP_NONE));
   c_err:   cover property (cfgErr_ff);
endmodule : cwd_channel_ctl

// *** cwd_defines.svh ***
// Offsets, field positions and codes of the channel control word block
`ifndef CWD_DEFINES_SVH
`define CWD_DEFINES_SVH

`define CWD_OFF_SRC_END   8'h00
`define CWD_OFF_DST_END   8'h04
`define CWD_OFF_CTL       8'h08
`define CWD_OFF_STATUS    8'h0c

`define CWD_DST_STEP_HI   31
`define CWD_DST_STEP_LO   30
`define CWD_DST_SIZE_HI   29
`define CWD_DST_SIZE_LO   28
`define CWD_SRC_STEP_HI   27
`define CWD_SRC_STEP_LO   26
`define CWD_SRC_SIZE_HI   25
`define CWD_SRC_SIZE_LO   24
`define CWD_ARB_HI        17
`define CWD_ARB_LO        14
`define CWD_CNT_HI        13
`define CWD_CNT_LO        4
`define CWD_MODE_HI       2
`define CWD_MODE_LO       0

`define CWD_STEP_NONE     2'h3
`define CWD_SIZE_RSVD     2'h3
`define CWD_ARB_CAP_CODE  4'ha
`define CWD_ARB_CAP_SHIFT 4'ha
`define CWD_MODE_STOP     3'h0

`define CWD_ST_BUSY       0
`define CWD_ST_ARBWAIT    1
`define CWD_ST_CFGERR     2

`endif

// *** cwd_mem_model.sv ***
// Memory partner that answers channel accesses after a chosen delay
`timescale 1ns/100ps
module cwd_mem_model (
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic [1:0]  lat,
   input  wire logic        memReq,
   input  wire logic        memWe,
   input  wire logic [31:0] memAddr,
   output logic             memAck,
   output logic      [31:0] memRdata
);
   logic [1:0]  cnt_ff;
   logic [31:0] last_ff;
   // Answer once the request has waited lat cycles
   assign memAck = memReq && (cnt_ff == lat);
   // Data lines change every cycle outside a read answer
   assign memRdata = (memAck && !memWe) ? (memAddr ^ 32'h5a5a0f0f)
                                        : ~last_ff;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_ff  <= 2'h0;
         last_ff <= 32'h0;
      end else begin
         cnt_ff  <= (memReq && !memAck) ? cnt_ff + 2'h1 : 2'h0;
         last_ff <= memRdata;
      end
   end
endmodule : cwd_mem_model

// *** cwd_pkg.sv ***
// Types shared by the channel control word block
package cwd_pkg;
   typedef enum logic [1:0] {
      IDLE,
      RD,
      WR,
      ARB
   } cwd_state_t;
endpackage : cwd_pkg

// *** tb.sv ***
// Self-checking bench for the channel control word block
`timescale 1ns/100ps
module tb;
   logic        clk;
   logic        rst_b;
   logic        regWrStb;
   logic        regRdStb;
   logic        memReq;
   logic        memWe;
   logic        memAck;
   logic        rearbReq;
   logic        arbGrant;
   logic [1:0]  lat;
   logic [1:0]  memSize;
   logic [7:0]  regAddr;
   logic [31:0] regWdata;
   logic [31:0] regRdata;
   logic [31:0] memAddr;
   logic [31:0] memWdata;
   logic [31:0] memRdata;
   logic [31:0] rdv;
   int          nMismatch;
   int          checks;

   cwd_channel_ctl i_cwd_channel_ctl (.clk(clk), .rst_b(rst_b),
      .regAddr(regAddr), .regWdata(regWdata), .regWrStb(regWrStb),
      .regRdStb(regRdStb), .regRdata(regRdata), .memReq(memReq),
      .memWe(memWe), .memAddr(memAddr), .memSize(memSize),
      .memWdata(memWdata), .memAck(memAck), .memRdata(memRdata),
      .rearbReq(rearbReq), .arbGrant(arbGrant));
   cwd_mem_model i_cwd_mem_model (.clk(clk), .rst_b(rst_b), .lat(lat),
      .memReq(memReq), .memWe(memWe), .memAddr(memAddr),
      .memAck(memAck), .memRdata(memRdata));

   task automatic chk(input string what, input logic [31:0] seen,
                      input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         nMismatch++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks, nMismatch);
      if (nMismatch == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : end_sim

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      regAddr  <= a;
      regWdata <= d;
      regWrStb <= 1'b1;
      @(posedge clk);
      regWrStb <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      regAddr  <= a;
      regRdStb <= 1'b1;
      @(posedge clk);
      regRdStb <= 1'b0;
      @(negedge clk);
      rdv = regRdata;
   endtask : rd

   // Equal widths and steps no smaller than width
   function automatic logic [31:0] mk(input logic [1:0] ds, sz, ss,
                                      input logic [3:0] arb,
                                      input logic [9:0] n);
      return {ds, sz, ss, sz, 6'h0, arb, n, 4'h1};
   endfunction : mk

   task automatic run(input logic [31:0] ctl, src, dst,
                      input logic [1:0] l);
      logic [9:0]  left;
      logic [31:0] ea;
      logic [31:0] rda;
      logic        gr;
      logic        done;
      int          nArb;
      int          burst;
      left  = ctl[13:4];
      burst = 1 << ((ctl[17:14] > 4'ha) ? 10 : ctl[17:14]);
      done  = 1'b0;
      nArb  = 0;
      rda   = 32'h0;
      wr(8'h00, src);
      lat <= l;
      wr(8'h04, dst);
      wr(8'h08, ctl);
      for (int i = 0; i < 4000 && !done; i++) begin
         @(negedge clk);
         if (memReq && memAck) begin
            chk("size", {30'h0, memSize}, {30'h0, ctl[25:24]});
            if (!memWe) begin
               ea  = (ctl[27:26] == 2'h3) ? src
                     : src - ({22'h0, left} << ctl[27:26]);
               rda = memAddr;
               chk("src addr", memAddr, ea);
            end else begin
               ea = (ctl[31:30] == 2'h3) ? dst
                    : dst - ({22'h0, left} << ctl[31:30]);
               chk("dst addr", memAddr, ea);
               chk("wdata", memWdata, rda ^ 32'h5a5a0f0f);
               done = (left == 10'h0);
               left = left - 10'h1;
            end
         end
         gr = rearbReq && !arbGrant;
         nArb += gr;
         @(posedge clk);
         arbGrant <= gr;
      end
      if (!done) begin
         nMismatch++;
         $display("[FAIL] transfer end expected done seen timeout");
         end_sim();
      end else begin
         chk("rearb count", nArb, ctl[13:4] / burst);
         rd(8'h08);
         chk("ctl end", rdv, {ctl[31:14], 10'h0, ctl[3], 3'h0});
         chk("req end", {31'h0, memReq}, 32'h0);
      end
   endtask : run

   task automatic t_regs();
      for (int a = 0; a < 20; a += 4) begin
         rd(a[7:0]);
         chk("reset read", rdv, 32'h0);
      end
      wr(8'h08, 32'h00fc0008);
      wr(8'h0c, 32'hffffffff);
      rd(8'h08);
      chk("ctl keep", rdv, 32'h00fc0008);
      rd(8'h0c);
      chk("status ro", rdv, 32'h0);
   endtask : t_regs

   task automatic t_rsvd();
      wr(8'h08, mk(2'h2, 2'h3, 2'h2, 4'h0, 10'h1));
      rd(8'h0c);
      chk("cfg err", rdv & 32'h7, 32'h4);
      chk("no start", {31'h0, memReq}, 32'h0);
   endtask : t_rsvd

   task automatic t_word();
      run(mk(2'h2, 2'h2, 2'h2, 4'h1, 10'h4), 32'h20000010,
          32'h30000020, 2'h0);
   endtask : t_word

   task automatic t_fixed();
      run(mk(2'h3, 2'h0, 2'h0, 4'h0, 10'h2), 32'h40000003,
          32'h50000001, 2'h2);
      run(mk(2'h0, 2'h0, 2'h3, 4'h0, 10'h1), 32'h40000003,
          32'h50000001, 2'h1);
   endtask : t_fixed

   task automatic t_half();
      run(mk(2'h1, 2'h1, 2'h2, 4'hc, 10'h3), 32'h60000100,
          32'h70000200, 2'h1);
      run(mk(2'h2, 2'h1, 2'h1, 4'h2, 10'h8), 32'h60000100,
          32'h70000200, 2'h0);
   endtask : t_half

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   initial begin
      rst_b     = 1'b0;
      regAddr   = 8'h00;
      regWdata  = 32'h0;
      regWrStb  = 1'b0;
      regRdStb  = 1'b0;
      arbGrant  = 1'b0;
      lat       = 2'h0;
      nMismatch = 0;
      checks    = 0;
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      t_regs();
      t_rsvd();
      t_word();
      t_fixed();
      t_half();
      end_sim();
   end
endmodule : tb
